//--- rtl/opmode_pkg.sv
// Constants, mode codes and carrier types of the operating mode controller
package opmode_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned INIT_TIME_NS    = 50000;
  localparam int unsigned INIT_CYC        = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_TIME_NS   = 100000;
  localparam int unsigned BLANK_CYC       = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_TIMEOUT_NS   = 1000000;
  localparam int unsigned WD_TIMEOUT_CYC  = WD_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int unsigned NUM_CH          = 6;
  localparam int unsigned NUM_FAIL_CH     = 4;
  localparam int unsigned NUM_OCW_CH      = 5;
  localparam int unsigned PAGE_W          = 3;
  localparam int unsigned SYNC_STAGES     = 3;

  // Pin vector positions of synchronised inputs
  localparam int unsigned PIN_DIR_LSB     = 0;
  localparam int unsigned PIN_RSTN        = 4;
  localparam int unsigned PIN_LIMP        = 5;
  localparam int unsigned PIN_BAT_OK      = 6;
  localparam int unsigned PIN_VCC_OK      = 7;
  localparam int unsigned NUM_PINS        = 8;

  localparam logic [NUM_PINS-1:0] PIN_RESET_VAL = 8'h00;
  localparam logic [NUM_CH-1:0]   CH_RESET_VAL  = 6'h00;

  typedef enum logic [3:0] {
    MODE_OFF    = 4'h1,
    MODE_SLEEP  = 4'h2,
    MODE_NORMAL = 4'h4,
    MODE_FAIL   = 4'h8
  } mode_t;

  typedef struct packed {
    logic                   write;
    logic                   wd_toggle;
    logic [NUM_CH-1:0]      channel_on_bit;
    logic [NUM_FAIL_CH-1:0] internal_input_sel;
    logic                   stuck;
    logic                   modulo_err;
    logic [PAGE_W-1:0]      status_page_select;
    logic                   quick_status1_read;
  } serial_in_t;

  typedef struct packed {
    logic [NUM_CH-1:0]      overtemp;
    logic [NUM_CH-1:0]      high_overcurrent_detect;
    logic [NUM_CH-1:0]      severe_short;
    logic [NUM_FAIL_CH-1:0] overload;
    logic                   undervoltage;
  } fault_in_t;

endpackage

//--- rtl/operating_mode_controller.sv
// Operating mode state machine with channel source selection and fail policy
`timescale 1ns/1ps

module operating_mode_controller #(
  parameter int unsigned WD_TIMEOUT = opmode_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned INIT_CYCLES = opmode_pkg::INIT_CYC,
  parameter int unsigned BLANK_CYCLES = opmode_pkg::BLANK_CYC
) (
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  active_low_reset_input_n_i,
  input  wire logic [opmode_pkg::NUM_FAIL_CH-1:0]    direct_control_inputs_i,
  input  wire logic                                  limp_home_i,
  input  wire logic                                  battery_above_por_i,
  input  wire logic                                  logic_supply_above_por_i,
  input  wire logic [opmode_pkg::NUM_FAIL_CH-1:0]    direct_input_wake_terms_i,
  input  wire opmode_pkg::serial_in_t                serial_i,
  input  wire opmode_pkg::fault_in_t                 fault_i,
  output opmode_pkg::mode_t                          mode_o,
  output logic [opmode_pkg::NUM_CH-1:0]              channel_drive_o,
  output logic [opmode_pkg::NUM_OCW_CH-1:0]          oc_window_start_o,
  output logic                                       low_overcurrent_threshold_o,
  output logic [opmode_pkg::NUM_FAIL_CH-1:0]         autorestart_o,
  output logic [opmode_pkg::NUM_CH-1:0]              latch_off_o,
  output logic                                       current_sense_output_en_o,
  output logic                                       current_sense_sync_en_o,
  output logic                                       serial_write_en_o,
  output logic                                       diag_avail_o,
  output logic [opmode_pkg::PAGE_W-1:0]              status_page_o,
  output logic                                       clear_serial_in_o,
  output logic                                       clear_serial_out_o,
  output logic                                       serial_regs_hold_o,
  output logic                                       fault_blank_o,
  output logic                                       init_done_o,
  output logic                                       serial_fail_o,
  output logic                                       device_status_flag_o,
  output logic                                       register_clear_flag_o
);
  import opmode_pkg::*;

  if (WD_TIMEOUT < 2 || INIT_CYCLES < 1 || BLANK_CYCLES < 1) begin : g_chk
    $error("operating_mode_controller: timing counts too small");
  end

  // Pin synchronisers, three stages; change accepted when stages two and three agree
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] s1_ff;
  logic [NUM_PINS-1:0] s2_ff;
  logic [NUM_PINS-1:0] s3_ff;
  logic [NUM_PINS-1:0] pin_ff;

  assign pins = {logic_supply_above_por_i, battery_above_por_i, limp_home_i,
                 active_low_reset_input_n_i, direct_control_inputs_i};

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        s1_ff[i]  <= PIN_RESET_VAL[i];
        s2_ff[i]  <= PIN_RESET_VAL[i];
        s3_ff[i]  <= PIN_RESET_VAL[i];
        pin_ff[i] <= PIN_RESET_VAL[i];
      end else begin
        s1_ff[i] <= pins[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          pin_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  logic [NUM_FAIL_CH-1:0] dir_in;
  logic                   rstn_pin;
  logic                   limp;
  logic                   supply_ok;
  logic                   wake;
  logic                   fail;

  assign dir_in    = pin_ff[PIN_DIR_LSB +: NUM_FAIL_CH];
  assign rstn_pin  = pin_ff[PIN_RSTN];
  assign limp      = pin_ff[PIN_LIMP];
  assign supply_ok = pin_ff[PIN_BAT_OK] | pin_ff[PIN_VCC_OK];
  assign wake      = (|direct_input_wake_terms_i) | rstn_pin;

  // Wake-up event: any rise of wake or of the reset pin
  logic wake_q_ff;
  logic rstn_q_ff;
  logic wake_evt;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wake_q_ff <= 1'b0;
      rstn_q_ff <= 1'b0;
    end else begin
      wake_q_ff <= wake;
      rstn_q_ff <= rstn_pin;
    end
  end

  assign wake_evt = (wake & ~wake_q_ff) | (rstn_pin & ~rstn_q_ff);

  // Mode machine
  mode_t mode_ff;
  mode_t nxt_mode;
  logic  serial_fail_ff;
  logic  recover_ok;
  logic  init_done;
  logic  to_fail;
  logic  to_normal;

  assign fail = serial_fail_ff | limp;

  always_comb begin
    nxt_mode = mode_ff;
    if (!supply_ok) begin
      nxt_mode = MODE_OFF;
    end else begin
      case (mode_ff)
        MODE_OFF: begin
          nxt_mode = MODE_SLEEP;
        end
        MODE_SLEEP: begin
          if (wake) begin
            // Wake-up clears the serial failure flag, so a stale one must not count
            nxt_mode = (limp || (serial_fail_ff && !wake_evt)) ? MODE_FAIL : MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          if (!wake) begin
            nxt_mode = MODE_SLEEP;
          end else if (fail) begin
            nxt_mode = MODE_FAIL;
          end
        end
        MODE_FAIL: begin
          if (!wake) begin
            nxt_mode = MODE_SLEEP;
          end else if (recover_ok && !limp) begin
            nxt_mode = MODE_NORMAL;
          end
        end
        default: begin
          nxt_mode = MODE_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_ff <= MODE_OFF;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  assign to_fail   = (mode_ff == MODE_NORMAL) && (nxt_mode == MODE_FAIL);
  assign to_normal = (mode_ff == MODE_FAIL) && (nxt_mode == MODE_NORMAL);

  // Initialisation and fault blanking timers, restarted on every wake-up
  logic [31:0] init_cnt_ff;
  logic [31:0] blank_cnt_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i || wake_evt) begin
      init_cnt_ff <= INIT_CYCLES;
    end else if (init_cnt_ff != 32'h0000_0000) begin
      init_cnt_ff <= init_cnt_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || wake_evt) begin
      blank_cnt_ff <= BLANK_CYCLES;
    end else if (blank_cnt_ff != 32'h0000_0000) begin
      blank_cnt_ff <= blank_cnt_ff - 32'h0000_0001;
    end
  end

  assign init_done = (init_cnt_ff == 32'h0000_0000);

  // Watchdog: each write must invert the toggle bit; silence beyond timeout fails
  logic [31:0] wd_cnt_ff;
  logic        wd_last_ff;
  logic        wd_timeout;
  logic        wd_seq_err;
  logic        wd_active;
  logic        rec_stage_ff;
  logic        rec_done_ff;

  assign wd_active  = (mode_ff == MODE_NORMAL) && init_done;
  assign wd_timeout = (wd_cnt_ff >= WD_TIMEOUT);
  assign wd_seq_err = serial_i.write && (serial_i.wd_toggle == wd_last_ff);

  always_ff @(posedge clock_i) begin
    if (rst_i || wake_evt || to_normal) begin
      wd_cnt_ff  <= 32'h0000_0000;
      wd_last_ff <= 1'b1;
    end else if (serial_i.write) begin
      wd_cnt_ff  <= 32'h0000_0000;
      wd_last_ff <= serial_i.wd_toggle;
    end else if (!wd_timeout) begin
      wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
    end
  end

  // Recovery: toggle 0 write, then toggle 1 write before the watchdog expires
  always_ff @(posedge clock_i) begin
    if (rst_i || mode_ff != MODE_FAIL) begin
      rec_stage_ff <= 1'b0;
      rec_done_ff  <= 1'b0;
    end else if (serial_i.write) begin
      rec_stage_ff <= ~serial_i.wd_toggle;
      rec_done_ff  <= rec_stage_ff && serial_i.wd_toggle && !wd_timeout;
    end else if (wd_timeout) begin
      rec_stage_ff <= 1'b0;
    end
  end

  assign recover_ok = rec_done_ff;

  // Serial failure flag; a new failure in the cycle of a clear still wins
  logic sf_set;
  logic sf_clr;

  assign sf_set = wd_active &&
                  (wd_timeout || wd_seq_err || serial_i.stuck || serial_i.modulo_err);
  assign sf_clr = wake_evt || to_normal;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      serial_fail_ff <= 1'b0;
    end else begin
      serial_fail_ff <= sf_set | (serial_fail_ff & ~sf_clr);
    end
  end

  // Diagnosis kept in fail mode entered from normal mode unless a stuck serial line is signalled there, whatever the failure cause
  logic diag_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      diag_ff <= 1'b0;
    end else if (mode_ff != MODE_FAIL) begin
      diag_ff <= (mode_ff == MODE_NORMAL);
    end else if (serial_i.stuck) begin
      diag_ff <= 1'b0;
    end
  end

  // Latch-off of outputs on severe faults in fail mode, held until next wake-up or reset pin low outside fail mode
  logic [NUM_CH-1:0] latch_ff;
  logic [NUM_CH-1:0] severe;
  logic              blanking;

  assign blanking = (blank_cnt_ff != 32'h0000_0000);
  assign severe   = fault_i.overtemp | fault_i.high_overcurrent_detect | fault_i.severe_short;

  always_ff @(posedge clock_i) begin
    if (rst_i || wake_evt || !rstn_pin && mode_ff != MODE_FAIL) begin
      latch_ff <= CH_RESET_VAL;
    end else if (mode_ff == MODE_FAIL && !blanking) begin
      latch_ff <= latch_ff | severe;
    end
  end

  // Channel source selection
  logic [NUM_CH-1:0]      nxt_drive;
  logic [NUM_CH-1:0]      drive_ff;
  logic [NUM_OCW_CH-1:0]  ocw_src;
  logic [NUM_OCW_CH-1:0]  ocw_q_ff;

  always_comb begin
    nxt_drive = CH_RESET_VAL;
    ocw_src   = drive_ff[NUM_OCW_CH-1:0];
    if (mode_ff == MODE_NORMAL && init_done) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (c < NUM_FAIL_CH && serial_i.internal_input_sel[c]) begin
          nxt_drive[c] = dir_in[c];
        end else begin
          nxt_drive[c] = serial_i.channel_on_bit[c];
        end
      end
    end else if (mode_ff == MODE_FAIL) begin
      nxt_drive[NUM_FAIL_CH-1:0] = dir_in & ~latch_ff[NUM_FAIL_CH-1:0];
      ocw_src[NUM_FAIL_CH-1:0]   = direct_input_wake_terms_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      drive_ff <= CH_RESET_VAL;
      ocw_q_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
      ocw_q_ff <= ocw_src;
    end
  end

  // Registered outputs
  logic in_fail;
  logic in_normal;

  assign in_fail   = (mode_ff == MODE_FAIL);
  assign in_normal = (mode_ff == MODE_NORMAL);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_o                      <= MODE_OFF;
      channel_drive_o             <= CH_RESET_VAL;
      oc_window_start_o           <= '0;
      low_overcurrent_threshold_o <= 1'b0;
      autorestart_o               <= '0;
      latch_off_o                 <= CH_RESET_VAL;
      current_sense_output_en_o   <= 1'b0;
      current_sense_sync_en_o     <= 1'b0;
      serial_write_en_o           <= 1'b0;
      diag_avail_o                <= 1'b0;
      status_page_o               <= '0;
      fault_blank_o               <= 1'b0;
      init_done_o                 <= 1'b0;
      serial_fail_o               <= 1'b0;
      serial_regs_hold_o          <= 1'b1;
    end else begin
      mode_o                      <= mode_ff;
      channel_drive_o             <= drive_ff;
      oc_window_start_o           <= ocw_src & ~ocw_q_ff;
      low_overcurrent_threshold_o <= in_fail;
      autorestart_o               <= {NUM_FAIL_CH{in_fail}} &
                                     (fault_i.overload | {NUM_FAIL_CH{fault_i.undervoltage}});
      latch_off_o                 <= latch_ff;
      current_sense_output_en_o   <= in_normal && init_done;
      current_sense_sync_en_o     <= in_normal && init_done;
      serial_write_en_o           <= in_normal && init_done && rstn_pin;
      diag_avail_o                <= diag_ff && (in_normal || in_fail);
      status_page_o               <= serial_i.status_page_select;
      fault_blank_o               <= blanking;
      init_done_o                 <= init_done;
      serial_fail_o               <= serial_fail_ff;
      serial_regs_hold_o          <= ~rstn_pin;
    end
  end

  // Register clear strobes and status flags
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clear_serial_in_o  <= 1'b0;
      clear_serial_out_o <= 1'b0;
    end else begin
      clear_serial_in_o  <= wake_evt | to_fail | to_normal;
      clear_serial_out_o <= wake_evt | to_normal;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      device_status_flag_o <= 1'b0;
    end else if (to_normal) begin
      device_status_flag_o <= 1'b1;
    end else if (wake_evt) begin
      device_status_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      register_clear_flag_o <= 1'b0;
    end else if (to_normal) begin
      register_clear_flag_o <= 1'b1;
    end else if (wake_evt || serial_i.quick_status1_read) begin
      register_clear_flag_o <= 1'b0;
    end
  end

endmodule

//--- tb/opmode_checker.sv
// Concurrent checks of mode, channel and flag behaviour of the mode controller
`timescale 1ns/1ps
module opmode_checker
  import opmode_pkg::*;
(
  input  wire logic                               clock_i,
  input  wire logic                               rst_i,
  input  wire opmode_pkg::serial_in_t             serial_i,
  input  wire opmode_pkg::mode_t                  mode_o,
  input  wire logic [opmode_pkg::NUM_CH-1:0]      channel_drive_o,
  input  wire logic [opmode_pkg::NUM_OCW_CH-1:0]  oc_window_start_o,
  input  wire logic                               low_overcurrent_threshold_o,
  input  wire logic [opmode_pkg::NUM_FAIL_CH-1:0] autorestart_o,
  input  wire logic                               current_sense_output_en_o,
  input  wire logic                               serial_write_en_o,
  input  wire logic                               init_done_o,
  input  wire logic                               device_status_flag_o,
  input  wire logic                               register_clear_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Two samples of one mode, so registered outputs have caught up
  sequence s_held(mode_t m);
    mode_o == m ##1 mode_o == m;
  endsequence
  sequence s_fail_to_normal;
    mode_o == MODE_FAIL ##1 mode_o == MODE_NORMAL;
  endsequence

  property p_sleep_off;
    s_held(MODE_SLEEP) |-> channel_drive_o == 6'h00;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("channel driven in sleep");
  property p_fail_off;
    s_held(MODE_FAIL) |-> channel_drive_o[5:4] == 2'h0;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("channel five or six on in fail");
  property p_fail_profile;
    s_held(MODE_FAIL) |-> low_overcurrent_threshold_o;
  endproperty
  a_fail_profile: assert property (p_fail_profile)
    else $error("low threshold profile missing in fail");
  property p_restart;
    autorestart_o != 4'h0 |-> low_overcurrent_threshold_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("autorestart outside fail");
  property p_sense;
    current_sense_output_en_o |-> !low_overcurrent_threshold_o;
  endproperty
  a_sense: assert property (p_sense)
    else $error("current sense enabled in fail");
  property p_write;
    serial_write_en_o |-> init_done_o;
  endproperty
  a_write: assert property (p_write)
    else $error("writes accepted before init");
  property p_recover;
    s_fail_to_normal |-> device_status_flag_o && register_clear_flag_o;
  endproperty
  a_recover: assert property (p_recover)
    else $error("status flags not set on recovery");
  property p_rcf_hold;
    register_clear_flag_o && !serial_i.quick_status1_read && mode_o == MODE_NORMAL
      |=> register_clear_flag_o;
  endproperty
  a_rcf_hold: assert property (p_rcf_hold)
    else $error("clear flag dropped without read");
  property p_rcf_clear;
    serial_i.quick_status1_read && mode_o == MODE_NORMAL |=> !register_clear_flag_o;
  endproperty
  a_rcf_clear: assert property (p_rcf_clear)
    else $error("clear flag kept after read");
  property p_oc_pulse;
    oc_window_start_o != 5'h00 |=> (oc_window_start_o & $past(oc_window_start_o)) == 5'h00;
  endproperty
  a_oc_pulse: assert property (p_oc_pulse)
    else $error("window start longer than one cycle");
endmodule

bind operating_mode_controller opmode_checker opmode_checker_inst (
  .clock_i(clock_i), .rst_i(rst_i), .serial_i(serial_i), .mode_o(mode_o),
  .channel_drive_o(channel_drive_o), .oc_window_start_o(oc_window_start_o),
  .low_overcurrent_threshold_o(low_overcurrent_threshold_o), .autorestart_o(autorestart_o),
  .current_sense_output_en_o(current_sense_output_en_o),
  .serial_write_en_o(serial_write_en_o), .init_done_o(init_done_o),
  .device_status_flag_o(device_status_flag_o), .register_clear_flag_o(register_clear_flag_o));

//--- tb/host_model.sv
// Host controller model: reset pin, limp-home, direct inputs and serial frames
`timescale 1ns/1ps
module host_model
  import opmode_pkg::*;
(
  input  wire logic                               clock_i,
  output logic                                    rstn_o,
  output logic                                    limp_o,
  output logic [opmode_pkg::NUM_FAIL_CH-1:0]      din_o,
  output opmode_pkg::serial_in_t                  serial_o
);
  logic wd_ff;
  initial begin
    rstn_o = 1'b0;
    limp_o = 1'b0;
    din_o = 4'h0;
    serial_o = '0;
    wd_ff = 1'b1;
  end
  // Reset pin rise after supplies are up is the wake event
  task automatic pins(input logic rstn, input logic limp, input logic [3:0] din);
    @(posedge clock_i);
    rstn_o <= rstn;
    limp_o <= limp;
    din_o <= din;
  endtask
  // Toggle inverted on every frame, first frame carries zero
  task automatic write_frame(input logic [5:0] on, input logic [3:0] sel);
    @(posedge clock_i);
    serial_o.write <= 1'b1;
    serial_o.wd_toggle <= ~wd_ff;
    serial_o.channel_on_bit <= on;
    serial_o.internal_input_sel <= sel;
    wd_ff = ~wd_ff;
    @(posedge clock_i);
    serial_o.write <= 1'b0;
  endtask
  task automatic pulse_read();
    @(posedge clock_i);
    serial_o.quick_status1_read <= 1'b1;
    @(posedge clock_i);
    serial_o.quick_status1_read <= 1'b0;
  endtask
  task automatic set_misc(input logic stuck, input logic [2:0] page);
    @(posedge clock_i);
    serial_o.stuck <= stuck;
    serial_o.status_page_select <= page;
  endtask
endmodule

//--- tb/operating_mode_controller_bench.sv
// Self-checking bench of the operating mode controller with a host model
`timescale 1ns/1ps
module operating_mode_controller_bench;
  import opmode_pkg::*;
  localparam int unsigned WD_T = 50;
  localparam int unsigned INIT_T = 8;
  logic       clock_i, rst_i, bat_ok, vcc_ok, rstn, limp, clr_acc, cin_seen, cout_seen;
  logic [3:0] din, wake_terms, autorestart;
  logic [5:0] drive, latch;
  logic [4:0] ocw, ocw_seen;
  logic [2:0] page;
  logic       low_oc, cs_en, cs_sync, wr_en, diag, clr_in, clr_out, hold, blank, init_done;
  logic       sfail, device_status_flag, register_clear_flag;
  serial_in_t ser;
  fault_in_t  fault;
  mode_t      mode;
  int         bad_count, comparisons;

  operating_mode_controller #(.WD_TIMEOUT(WD_T), .INIT_CYCLES(INIT_T), .BLANK_CYCLES(8))
    operating_mode_controller_inst (
    .clock_i(clock_i), .rst_i(rst_i), .active_low_reset_input_n_i(rstn),
    .direct_control_inputs_i(din), .limp_home_i(limp), .battery_above_por_i(bat_ok),
    .logic_supply_above_por_i(vcc_ok), .direct_input_wake_terms_i(wake_terms),
    .serial_i(ser), .fault_i(fault), .mode_o(mode), .channel_drive_o(drive),
    .oc_window_start_o(ocw), .low_overcurrent_threshold_o(low_oc),
    .autorestart_o(autorestart), .latch_off_o(latch), .current_sense_output_en_o(cs_en),
    .current_sense_sync_en_o(cs_sync), .serial_write_en_o(wr_en), .diag_avail_o(diag),
    .status_page_o(page), .clear_serial_in_o(clr_in), .clear_serial_out_o(clr_out),
    .serial_regs_hold_o(hold), .fault_blank_o(blank), .init_done_o(init_done),
    .serial_fail_o(sfail), .device_status_flag_o(device_status_flag), .register_clear_flag_o(register_clear_flag));
  host_model host_model_inst (.clock_i(clock_i), .rstn_o(rstn), .limp_o(limp), .din_o(din),
    .serial_o(ser));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // Pulses are collected so a one-cycle output is never missed
  always @(posedge clock_i) begin
    ocw_seen <= clr_acc ? 5'h00 : (ocw_seen | ocw);
    cin_seen <= clr_acc ? 1'b0 : (cin_seen | clr_in);
    cout_seen <= clr_acc ? 1'b0 : (cout_seen | clr_out);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_mode(input mode_t m);
    for (int i = 0; i < 100 && mode !== m; i++) step(1);
  endtask
  task automatic clear_acc();
    @(posedge clock_i);
    clr_acc <= 1'b1;
    @(posedge clock_i);
    clr_acc <= 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_power();
    step(6);
    check(mode, MODE_OFF);
    @(posedge clock_i);
    bat_ok <= 1'b1;
    wait_mode(MODE_SLEEP);
    check(mode, MODE_SLEEP);
    step(2);
    check(drive, 6'h00);
    check(hold, 1'b1);
    @(posedge clock_i);
    vcc_ok <= 1'b1;
    $display("test power done");
  endtask
  task automatic t_wake();
    clear_acc();
    host_model_inst.pins(1'b1, 1'b0, 4'h0);
    wait_mode(MODE_NORMAL);
    check(mode, MODE_NORMAL);
    check({init_done, blank, cin_seen, cout_seen}, 4'h7);
    step(INIT_T + 4);
    check({init_done, wr_en, cs_en, blank, hold}, 5'h1C);
    clear_acc();
    host_model_inst.write_frame(6'h2A, 4'h0);
    step(6);
    check({drive, ocw_seen}, {6'h2A, 5'h0A});
    clear_acc();
    host_model_inst.pins(1'b1, 1'b0, 4'h5);
    host_model_inst.write_frame(6'h00, 4'h5);
    step(6);
    check({drive, ocw_seen}, {6'h05, 5'h05});
    $display("test wake done");
  endtask
  task automatic t_fail();
    clear_acc();
    host_model_inst.set_misc(1'b0, 3'h5);
    host_model_inst.pins(1'b1, 1'b1, 4'h9);
    wait_mode(MODE_FAIL);
    check(mode, MODE_FAIL);
    step(4);
    check(drive, 6'h09);
    check({low_oc, cs_en, cs_sync, wr_en, diag}, 5'h11);
    check({page, cin_seen, cout_seen}, 5'h16);
    @(posedge clock_i);
    fault.undervoltage <= 1'b1;
    step(3);
    check(autorestart, 4'hF);
    @(posedge clock_i);
    fault.undervoltage <= 1'b0;
    fault.severe_short <= 6'h01;
    @(posedge clock_i);
    fault.severe_short <= 6'h00;
    step(3);
    check({latch[0], drive}, 7'h48);
    clear_acc();
    @(posedge clock_i);
    wake_terms <= 4'h3;
    step(3);
    check(ocw_seen, 5'h03);
    @(posedge clock_i);
    wake_terms <= 4'h0;
    $display("test fail done");
  endtask
  task automatic t_recover();
    clear_acc();
    host_model_inst.pins(1'b1, 1'b0, 4'h9);
    step(5);
    host_model_inst.write_frame(6'h3F, 4'h0);
    step(3);
    check(drive, 6'h08);
    host_model_inst.write_frame(6'h3F, 4'h0);
    wait_mode(MODE_NORMAL);
    check(mode, MODE_NORMAL);
    check({device_status_flag, register_clear_flag, cout_seen}, 3'h7);
    step(6);
    check(register_clear_flag, 1'b1);
    host_model_inst.pulse_read();
    step(2);
    check(register_clear_flag, 1'b0);
    $display("test recover done");
  endtask
  task automatic t_timeout();
    wait_mode(MODE_FAIL);
    check(mode, MODE_FAIL);
    check({sfail, diag}, 2'h3);
    host_model_inst.set_misc(1'b1, 3'h0);
    step(3);
    check(diag, 1'b0);
    host_model_inst.set_misc(1'b0, 3'h0);
    host_model_inst.pins(1'b0, 1'b0, 4'h0);
    wait_mode(MODE_SLEEP);
    check(mode, MODE_SLEEP);
    clear_acc();
    @(posedge clock_i);
    wake_terms <= 4'h2;
    wait_mode(MODE_NORMAL);
    check(mode, MODE_NORMAL);
    check({sfail, latch[0], cout_seen}, 3'h1);
    $display("test timeout done");
  endtask

  // Whole sequence takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    bad_count++;
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    bat_ok = 1'b0;
    vcc_ok = 1'b0;
    clr_acc = 1'b0;
    wake_terms = 4'h0;
    fault = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_power();
    t_wake();
    t_fail();
    t_recover();
    t_timeout();
    final_report();
  end
endmodule
